/* adc_offset_dma_sync_ctrl.sv */
// converter wrapper: control one, reference select, offset trim, results, DMA sync
`timescale 1ns/1ps
module adc_offset_dma_sync_ctrl
  import adc_wrap_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire cpu_req_t          cpuReq,
  output logic [DATA_W-1:0]      cpuRdData,
  input  wire logic              dmaRdEn,
  input  wire logic [ADDR_W-1:0] dmaAddr,
  output logic [DATA_W-1:0]      dmaRdData,
  input  wire logic              startTrigger,
  input  wire logic              debugHalt,
  input  wire logic [IDX_W-1:0]  maxConvCount,
  input  wire conv_in_t          convIn,
  output logic                   sampleSwitch,
  output logic                   dmaSync,
  output logic                   useExternalRef
);
  logic [1:0]        rstPipe_r;
  logic              rstN;
  logic [1:0]        swRstCnt_r;
  logic              softRst;
  ctrl_t             ctrl_r;
  logic [1:0]        refSel_r;
  logic [TRIM_W-1:0] offset_trim_field_r;
  logic              useExtRef_r;
  logic [DATA_W-1:0] cpuRdData_r;
  logic [DATA_W-1:0] dmaRdData_r;
  logic              sampleSwitch_r;
  logic              dmaSync_r;
  logic [RES_W-1:0]  resultMem_r [RES_N];
  seq_state_t        state_r;
  seq_state_t        state_nxt;
  logic [3:0]        sampleCnt_r;
  logic [IDX_W-1:0]  resIdx_r;
  logic [IDX_W-1:0]  boundCnt_r;
  logic              syncDone_r;

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      rstPipe_r <= 2'b00;
    else
      rstPipe_r <= {rstPipe_r[0], 1'b1};
  end
  assign rstN = rstPipe_r[1];

  // address decode
  wire cpuCtrlHit = cpuReq.addr == CTRL_ONE_ADDR;
  wire cpuRefHit  = cpuReq.addr == REFSEL_ADDR;
  wire cpuTrimHit = cpuReq.addr == OFFSET_TRIM_FIELD_ADDR;
  wire cpuResHit  = cpuReq.addr >= RES_DMA_LO && cpuReq.addr <= RES_DMA_HI;
  wire cpuMirHit  = cpuReq.addr >= RES_MIR_LO && cpuReq.addr <= RES_MIR_HI;
  wire dmaResHit  = dmaAddr >= RES_DMA_LO && dmaAddr <= RES_DMA_HI;
  wire [IDX_W-1:0] cpuIdx = cpuResHit ? cpuReq.addr[IDX_W-1:0] : {1'b0, cpuReq.addr[2:0]};
  wire ctrlWr   = cpuReq.wrEn && cpuCtrlHit && !softRst;
  wire modRstWr = ctrlWr && cpuReq.wdata[CTRL_RST_BIT];
  assign softRst = swRstCnt_r != 2'h0;

  // control one read: reset bit and reserved bits are never stored
  wire [DATA_W-1:0] ctrlRead = ctrl_r & CTRL_WMASK;
  wire [DATA_W-1:0] cpuRdNxt =
    cpuCtrlHit ? ctrlRead :
    cpuRefHit  ? {refSel_r, 14'h0000} :
    cpuTrimHit ? {7'h00, offset_trim_field_r} :
    (cpuResHit || cpuMirHit) ? {4'h0, resultMem_r[cpuIdx]} : 16'h0000;
  wire [DATA_W-1:0] dmaRdNxt =
    dmaResHit ? {4'h0, resultMem_r[dmaAddr[IDX_W-1:0]]} : 16'h0000;

  // signed trim applied in the same cycle the result is stored
  wire signed [13:0] trimSum =
    $signed({2'b00, convIn.raw}) + $signed({{5{offset_trim_field_r[TRIM_W-1]}}, offset_trim_field_r});
  wire [RES_W-1:0] trimmed =
    trimSum < 0 ? 12'h000 :
    trimSum > $signed({2'b00, CODE_MAX}) ? CODE_MAX : trimSum[RES_W-1:0];

  // sequencer decode
  wire freeze    = debugHalt && ctrl_r.suspMode == SUSP_NOW;
  wire holdConv  = debugHalt && ctrl_r.suspMode == SUSP_CONV;
  wire holdSeq   = debugHalt && (ctrl_r.suspMode == SUSP_SEQ || holdConv);
  wire [IDX_W-1:0] wrapIdx =
    ctrl_r.seqOverride ? (ctrl_r.cascade ? WRAP_FULL : WRAP_HALF) : maxConvCount;
  wire storeEn   = state_r == SEQ_CONVERT && convIn.done && !freeze;
  wire passEnd   = storeEn && resIdx_r == wrapIdx;
  wire boundary  = storeEn && boundCnt_r == maxConvCount;
  wire syncMode  = ctrl_r.seqOverride && ctrl_r.contRun;
  wire syncFire  = syncMode && boundary && !syncDone_r;
  wire sampleEnd = sampleCnt_r == ctrl_r.sampleWin;

  always_comb
  begin
    state_nxt = state_r;
    if (!freeze)
    begin
      unique case (state_r)
        SEQ_IDLE:
          if ((startTrigger || ctrl_r.contRun) && !holdSeq)
            state_nxt = SEQ_SAMPLE;
        SEQ_SAMPLE:
          if (sampleEnd)
            state_nxt = SEQ_CONVERT;
        SEQ_CONVERT:
          if (passEnd)
            state_nxt = (ctrl_r.contRun && !holdSeq) ? SEQ_SAMPLE : SEQ_IDLE;
          else if (storeEn)
            state_nxt = holdConv ? SEQ_HOLD : SEQ_SAMPLE;
        SEQ_HOLD:
          if (!holdConv)
            state_nxt = SEQ_SAMPLE;
      endcase
    end
  end

  // two-cycle module reset counter, loaded by the reset-bit write, counts down to zero by itself, also cleared by the pin reset
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      swRstCnt_r <= 2'h0;
    else if (modRstWr)
      swRstCnt_r <= SW_RST_CYCLES;
    else if (softRst)
      swRstCnt_r <= swRstCnt_r - 2'h1;
  end

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      ctrl_r      <= '0;
      refSel_r    <= REF_INTERNAL;
      offset_trim_field_r   <= '0;
      useExtRef_r <= 1'b0;
    end
    else if (softRst || modRstWr)
    begin
      ctrl_r      <= '0;
      refSel_r    <= REF_INTERNAL;
      offset_trim_field_r   <= '0;
      useExtRef_r <= 1'b0;
    end
    else if (cpuReq.wrEn)
    begin
      if (cpuCtrlHit)
        ctrl_r <= ctrl_t'(cpuReq.wdata & CTRL_WMASK);
      if (cpuRefHit)
      begin
        refSel_r    <= cpuReq.wdata[REFSEL_LSB +: 2];
        useExtRef_r <= cpuReq.wdata[REFSEL_LSB +: 2] == REF_EXTERNAL;
      end
      if (cpuTrimHit)
        offset_trim_field_r <= cpuReq.wdata[TRIM_W-1:0];
    end
  end

  // both read ports answer one cycle after the request, independently
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      cpuRdData_r <= '0;
      dmaRdData_r <= '0;
    end
    else
    begin
      cpuRdData_r <= cpuReq.rdEn ? cpuRdNxt : 16'h0000;
      dmaRdData_r <= dmaRdEn ? dmaRdNxt : 16'h0000;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < RES_N; gi++)
    begin : g_result
      always_ff @(posedge clk or negedge rstN)
      begin
        if (!rstN)
          resultMem_r[gi] <= '0;
        else if (softRst || modRstWr)
          resultMem_r[gi] <= '0;
        else if (storeEn && resIdx_r == IDX_W'(gi))
          resultMem_r[gi] <= trimmed;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
    begin
      state_r        <= SEQ_IDLE;
      sampleCnt_r    <= '0;
      resIdx_r       <= '0;
      boundCnt_r     <= '0;
      syncDone_r     <= 1'b0;
      sampleSwitch_r <= 1'b0;
      dmaSync_r      <= 1'b0;
    end
    else if (softRst || modRstWr)
    begin
      state_r        <= SEQ_IDLE;
      sampleCnt_r    <= '0;
      resIdx_r       <= '0;
      boundCnt_r     <= '0;
      syncDone_r     <= 1'b0;
      sampleSwitch_r <= 1'b0;
      dmaSync_r      <= 1'b0;
    end
    else
    begin
      state_r        <= state_nxt;
      sampleSwitch_r <= state_nxt == SEQ_SAMPLE;
      dmaSync_r      <= syncFire;
      if (!freeze)
      begin
        sampleCnt_r <= (state_r == SEQ_SAMPLE && !sampleEnd) ? sampleCnt_r + 4'h1 : 4'h0;
        if (storeEn)
        begin
          resIdx_r   <= passEnd ? 4'h0 : resIdx_r + 4'h1;
          boundCnt_r <= (boundary || passEnd) ? 4'h0 : boundCnt_r + 4'h1;
        end
        if (passEnd)
          syncDone_r <= 1'b0;
        else if (syncFire)
          syncDone_r <= 1'b1;
      end
    end
  end

  assign cpuRdData      = cpuRdData_r;
  assign dmaRdData      = dmaRdData_r;
  assign sampleSwitch   = sampleSwitch_r;
  assign dmaSync        = dmaSync_r;
  assign useExternalRef = useExtRef_r;

  // helper: length of the current sample pulse
  logic [4:0] socLen_r;
  always_ff @(posedge clk or negedge rstN)
  begin
    if (!rstN)
      socLen_r <= '0;
    else if (!sampleSwitch_r)
      socLen_r <= 5'h00;
    else if (!freeze)
      socLen_r <= socLen_r + 5'h01; // frozen cycles do not count
  end

  sequence s_modRstWrite;
    cpuReq.wrEn && cpuCtrlHit && cpuReq.wdata[CTRL_RST_BIT] && !softRst;
  endsequence
  sequence s_heldInReset;
    softRst && state_r == SEQ_IDLE && ctrl_r == '0;
  endsequence

  AST_REF_SOURCE: assert property (@(posedge clk) disable iff (!rstN)
    useExternalRef |-> refSel_r == REF_EXTERNAL)
    else $error("external reference used without selection");
  AST_TRIM_NO_LATENCY: assert property (@(posedge clk) disable iff (!rstN || softRst)
    storeEn |=> resultMem_r[$past(resIdx_r)] == $past(trimmed))
    else $error("trimmed result not stored next cycle");
  AST_TRIM_RANGE: assert property (@(posedge clk) disable iff (!rstN)
    (convIn.raw == CODE_MAX && !offset_trim_field_r[TRIM_W-1]) |-> trimmed == CODE_MAX)
    else $error("top code lost under positive trim");
  AST_DUAL_READ: assert property (@(posedge clk) disable iff (!rstN)
    (cpuReq.rdEn && cpuResHit && dmaRdEn && dmaAddr == cpuReq.addr && !storeEn)
    |=> cpuRdData == dmaRdData)
    else $error("simultaneous reads disagree");
  AST_MIRROR_NO_DMA: assert property (@(posedge clk) disable iff (!rstN)
    (dmaRdEn && dmaAddr >= RES_MIR_LO && dmaAddr <= RES_MIR_HI) |=> dmaRdData == 16'h0000)
    else $error("DMA reached mirror window");
  AST_SYNC_MODE: assert property (@(posedge clk) disable iff (!rstN)
    dmaSync |-> $past(syncMode) && $past(boundary))
    else $error("sync pulse outside override continuous mode");
  AST_SYNC_PULSE: assert property (@(posedge clk) disable iff (!rstN)
    dmaSync |=> !dmaSync)
    else $error("sync pulse longer than one cycle");
  AST_CTRL_READ_ZERO: assert property (@(posedge clk) disable iff (!rstN)
    (cpuReq.rdEn && cpuCtrlHit) |=> cpuRdData[15:14] == 2'b00 && cpuRdData[3:0] == 4'h0)
    else $error("reserved or reset bits read nonzero");
  AST_MOD_RESET: assert property (@(posedge clk) disable iff (!rstN)
    s_modRstWrite |=> s_heldInReset ##1 s_heldInReset ##1 !softRst)
    else $error("module reset not held two cycles");
  AST_SOC_WIDTH: assert property (@(posedge clk) disable iff (!rstN || softRst)
    (sampleSwitch && !freeze ##1 !sampleSwitch) |-> socLen_r == 5'($past(ctrl_r.sampleWin, 2)) + 5'h01)
    else $error("sample pulse width wrong");
  AST_FREEZE: assert property (@(posedge clk) disable iff (!rstN || softRst)
    (freeze && !modRstWr) |=> $stable(resIdx_r) && $stable(sampleCnt_r))
    else $error("sequencer moved while stopped");
  AST_RESET_CLEARS: assert property (@(posedge clk) disable iff (!rstN)
    s_modRstWrite |=> !sampleSwitch && !dmaSync && !useExternalRef && resultMem_r[0] == '0)
    else $error("module reset write left state behind");
  AST_CTRL_WRITE: assert property (@(posedge clk) disable iff (!rstN)
    (ctrlWr && !modRstWr) |=> ctrl_r == ctrl_t'($past(cpuReq.wdata) & CTRL_WMASK))
    else $error("control one write not stored");
  AST_TRIM_WRITE: assert property (@(posedge clk) disable iff (!rstN)
    (cpuReq.wrEn && cpuTrimHit && !softRst) |=> offset_trim_field_r == $past(cpuReq.wdata[TRIM_W-1:0]))
    else $error("trim write not stored");
  AST_DMA_READ: assert property (@(posedge clk) disable iff (!rstN)
    (dmaRdEn && dmaResHit) |=> dmaRdData == {4'h0, $past(resultMem_r[dmaAddr[IDX_W-1:0]])})
    else $error("DMA read returned wrong result");
endmodule : adc_offset_dma_sync_ctrl

/* adc_wrap_pkg.sv */
// package: register map, field layout, encodings and types of the converter wrapper
// Notes on behaviour
// - internal bandgap after reset; external only when selected
// - nine-bit trim added to every result before storing
// - trim adds no cycle of latency
// - trimmed result clamps, full code range stays reachable
// - sixteen results readable by DMA at 0x0b00-0x0b0f
// - processor and DMA reads served same cycle
// - mirror 0x7108-0x710f is processor only
// - DMA sync only with override and continuous run
// - one sync per pass at first boundary
// - control one fields at offset zero, reset zero
// - bit 15 and bits 3-0 read zero
// - reset bit returns whole block to reset
// - reset bit self-clears and reads zero
// - module reset spans two clock cycles
// - suspend field selects debug halt behaviour
// - sample pulse lasts window plus one cycles
package adc_wrap_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int RES_W  = 12;
  localparam int TRIM_W = 9;
  localparam int RES_N  = 16;
  localparam int IDX_W  = 4;

  localparam logic [ADDR_W-1:0] CTRL_ONE_ADDR = 16'h7100;
  localparam logic [ADDR_W-1:0] REFSEL_ADDR   = 16'h711c;
  localparam logic [ADDR_W-1:0] OFFSET_TRIM_FIELD_ADDR  = 16'h711d;
  localparam logic [ADDR_W-1:0] RES_DMA_LO    = 16'h0b00;
  localparam logic [ADDR_W-1:0] RES_DMA_HI    = 16'h0b0f;
  localparam logic [ADDR_W-1:0] RES_MIR_LO    = 16'h7108;
  localparam logic [ADDR_W-1:0] RES_MIR_HI    = 16'h710f;

  localparam logic [DATA_W-1:0] CTRL_WMASK    = 16'h3ff0;
  localparam int                CTRL_RST_BIT  = 14;
  localparam int                REFSEL_LSB    = 14;
  localparam logic [1:0]        REF_INTERNAL  = 2'h0;
  localparam logic [1:0]        REF_EXTERNAL  = 2'h1;
  localparam logic [1:0]        SW_RST_CYCLES = 2'h2;

  localparam logic [1:0] SUSP_IGNORE = 2'h0;
  localparam logic [1:0] SUSP_SEQ    = 2'h1;
  localparam logic [1:0] SUSP_CONV   = 2'h2;
  localparam logic [1:0] SUSP_NOW    = 2'h3;

  localparam logic [IDX_W-1:0] WRAP_HALF = 4'h7;
  localparam logic [IDX_W-1:0] WRAP_FULL = 4'hf;
  localparam logic [RES_W-1:0] CODE_MAX  = 12'hfff;

  typedef struct packed {
    logic       rsvdTop;
    logic       modReset;
    logic [1:0] suspMode;
    logic [3:0] sampleWin;
    logic       clkDiv;
    logic       contRun;
    logic       seqOverride;
    logic       cascade;
    logic [3:0] rsvdLow;
  } ctrl_t;

  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cpu_req_t;

  typedef struct packed {
    logic             done;
    logic [RES_W-1:0] raw;
  } conv_in_t;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT, SEQ_HOLD} seq_state_t;
endpackage : adc_wrap_pkg

/* dma_sync_partner.sv */
// DMA controller model: reads the result window and watches the sync pulse
`timescale 1ns/1ps
module dma_sync_partner
  import adc_wrap_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              dmaSync,
  input  wire logic [DATA_W-1:0] dmaRdData,
  output logic                   dmaRdEn,
  output logic [ADDR_W-1:0]      dmaAddr,
  output int                     syncCnt,
  output logic                   syncErr
);
  int   xferPos;
  logic syncLast;

  initial
  begin
    dmaRdEn = 1'b0;
    dmaAddr = 16'h0000;
    xferPos = 0;
  end

  // optional idle gap before the request; address inverted once released
  task automatic rd(input logic [ADDR_W-1:0] a, input int gap, output logic [DATA_W-1:0] d);
    repeat (gap) @(posedge clk);
    #1;
    dmaRdEn = 1'b1;
    dmaAddr = a;
    @(posedge clk);
    #1;
    d = dmaRdData;
    dmaRdEn = 1'b0;
    dmaAddr = ~a;
    xferPos = (xferPos + 1) % RES_N;
  endtask : rd

  task automatic align();
    xferPos = 0;
  endtask : align

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      syncCnt  <= 0;
      syncErr  <= 1'b0;
      syncLast <= 1'b0;
    end
    else
    begin
      syncLast <= dmaSync;
      if (dmaSync && !syncLast)
        syncCnt <= syncCnt + 1;
      if (dmaSync && (syncLast || xferPos != 0))
        syncErr <= 1'b1;
    end
  end
endmodule : dma_sync_partner

/* adc_offset_dma_sync_ctrl_tb_top.sv */
// testbench: registers, trimmed results, shared reads and DMA sync of the converter wrapper
`timescale 1ns/1ps
module adc_offset_dma_sync_ctrl_tb_top;
  import adc_wrap_pkg::*;
  logic              clk;
  logic              nrst;
  cpu_req_t          cpuReq;
  logic [DATA_W-1:0] cpuRdData;
  logic              dmaRdEn;
  logic [ADDR_W-1:0] dmaAddr;
  logic [DATA_W-1:0] dmaRdData;
  logic              startTrigger;
  logic              debugHalt;
  logic [IDX_W-1:0]  maxConvCount;
  conv_in_t          convIn;
  logic              sampleSwitch;
  logic              dmaSync;
  logic              useExternalRef;
  int                syncCnt;
  logic              syncErr;
  int                miscompares;
  int                comparisons;
  int                highCnt;
  int                base;
  logic [31:0]       rngState;
  logic [DATA_W-1:0] cpuVal;
  logic [DATA_W-1:0] dmaVal;
  logic [8:0]        trim;
  logic [RES_W-1:0]  raw;
  logic [3:0]        win;
  logic [DATA_W-1:0] ctrlTab [3] = '{16'h0060, 16'h0070, 16'h0040};
  logic [DATA_W-1:0] syncTab [3] = '{16'h0002, 16'h0001, 16'h0000};

  adc_offset_dma_sync_ctrl adc_offset_dma_sync_ctrl_i (.clk(clk), .nrst(nrst), .cpuReq(cpuReq),
    .cpuRdData(cpuRdData), .dmaRdEn(dmaRdEn), .dmaAddr(dmaAddr), .dmaRdData(dmaRdData),
    .startTrigger(startTrigger), .debugHalt(debugHalt), .maxConvCount(maxConvCount),
    .convIn(convIn), .sampleSwitch(sampleSwitch), .dmaSync(dmaSync),
    .useExternalRef(useExternalRef));
  dma_sync_partner dma_sync_partner_i (.clk(clk), .nrst(nrst), .dmaSync(dmaSync),
    .dmaRdData(dmaRdData), .dmaRdEn(dmaRdEn), .dmaAddr(dmaAddr), .syncCnt(syncCnt),
    .syncErr(syncErr));

  always #2 clk = ~clk;

  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction : rnd

  // signed trim added, then held inside the twelve-bit code range
  function automatic logic [DATA_W-1:0] trimmed(input logic [RES_W-1:0] r, input logic [8:0] t);
    int s;
    s = int'(r) + int'($signed(t));
    if (s < 0)
      s = 0;
    if (s > 4095)
      s = 4095;
    return 16'(s);
  endfunction : trimmed

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    cpuReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1;
    cpuReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    cpuReq = '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    #1;
    d = cpuRdData;
    cpuReq = '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: 16'hffff};
    @(posedge clk);
    #1;
  endtask : rd

  // module reset, then the two-cycle quiet time before further writes
  task automatic softReset();
    wr(CTRL_ONE_ADDR, 16'h4000);
    repeat (2) @(posedge clk);
    #1;
  endtask : softReset

  // waits for one sampling window, counts its length, then delivers a result
  task automatic conv(input logic [RES_W-1:0] r, output int n);
    n = 0;
    for (int k = 0; k < 200 && sampleSwitch !== 1'b1; k++)
      @(posedge clk) #1;
    while (sampleSwitch === 1'b1 && n < 40)
    begin
      @(posedge clk) #1;
      n++;
    end
    convIn = '{done: 1'b1, raw: r};
    @(posedge clk);
    #1;
    convIn = '{done: 1'b0, raw: ~r};
  endtask : conv

  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (5000) @(posedge clk);
    miscompares++;
    give_verdict();
  end

  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    rngState = 32'd1497;
    cpuReq = '0;
    startTrigger = 1'b0;
    debugHalt = 1'b0;
    maxConvCount = 4'h0;
    convIn = '0;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rd(CTRL_ONE_ADDR, cpuVal);
    chk(cpuVal, 16'h0000);
    chk({15'h0000, useExternalRef}, 16'h0000);
    wr(REFSEL_ADDR, 16'h4000);
    rd(REFSEL_ADDR, cpuVal);
    chk(cpuVal, 16'h4000);
    chk({15'h0000, useExternalRef}, 16'h0001);
    wr(CTRL_ONE_ADDR, 16'hbfbf);
    rd(CTRL_ONE_ADDR, cpuVal);
    chk(cpuVal, 16'h3fb0);
    wr(CTRL_ONE_ADDR, 16'h4000);
    wr(CTRL_ONE_ADDR, 16'h0040);
    @(posedge clk);
    #1;
    rd(CTRL_ONE_ADDR, cpuVal);
    chk(cpuVal, 16'h0000);
    chk({15'h0000, useExternalRef}, 16'h0000);
    $display("test registers done");
    for (int i = 0; i < 6; i++)
    begin
      trim = (i == 0) ? 9'h1ec : (i == 1) ? 9'h0ff : 9'(rnd());
      raw = (i == 0) ? 12'h010 : (i == 1) ? 12'hfff : 12'(rnd());
      win = 4'(rnd());
      wr(OFFSET_TRIM_FIELD_ADDR, {7'h00, trim});
      wr(CTRL_ONE_ADDR, {4'h0, win, 8'h00});
      startTrigger = 1'b1;
      @(posedge clk);
      #1;
      startTrigger = 1'b0;
      conv(raw, highCnt);
      chk(16'(highCnt), 16'(win) + 16'h0001);
      fork
        rd(RES_DMA_LO, cpuVal);
        dma_sync_partner_i.rd(RES_DMA_LO, 0, dmaVal);
      join
      chk(cpuVal, trimmed(raw, trim));
      chk(dmaVal, trimmed(raw, trim));
      rd(RES_MIR_LO, cpuVal);
      chk(cpuVal, trimmed(raw, trim));
      dma_sync_partner_i.rd(RES_MIR_LO, 2, dmaVal);
      chk(dmaVal, 16'h0000);
    end
    $display("test trimmed results done");
    maxConvCount = 4'h3;
    for (int j = 0; j < 3; j++)
    begin
      softReset();
      dma_sync_partner_i.align();
      base = syncCnt;
      wr(CTRL_ONE_ADDR, ctrlTab[j]);
      repeat (16) conv(12'(rnd()), highCnt);
      repeat (4) @(posedge clk);
      #1;
      chk(16'(syncCnt - base), syncTab[j]);
      chk({15'h0000, syncErr}, 16'h0000);
    end
    $display("test dma sync done");
    maxConvCount = 4'h0;
    softReset();
    // halt raised during a three-cycle window, for each suspend mode
    for (int m = 0; m < 4; m++)
    begin
      raw = 12'(rnd());
      wr(CTRL_ONE_ADDR, {2'b00, 2'(m), 4'h2, 8'h00});
      startTrigger = 1'b1;
      @(posedge clk);
      #1;
      startTrigger = 1'b0;
      fork
        conv(raw, highCnt);
        begin
          @(posedge clk);
          #1;
          debugHalt = 1'b1;
          repeat (3) @(posedge clk);
          #1;
          debugHalt = 1'b0;
        end
      join
      chk(16'(highCnt), (m == 3) ? 16'h0006 : 16'h0003);
      rd(RES_DMA_LO, cpuVal);
      chk(cpuVal, trimmed(raw, 9'h000));
    end
    $display("test debug halt done");
    give_verdict();
  end
endmodule : adc_offset_dma_sync_ctrl_tb_top
